// ---- bsc_pkg.sv ----
package bsc_pkg;

    // Instruction word geometry
    localparam int unsigned IW_W         = 10;
    localparam int unsigned NIB_W        = 4;
    localparam int unsigned BSEL_W       = 2;
    localparam int unsigned BSEL_LSB     = 0;
    localparam int unsigned IMM_LSB      = 0;

    // First-word opcodes: pattern and compare mask
    localparam logic [9:0] OP_SETBIT     = 10'h05c;
    localparam logic [9:0] MSK_SETBIT    = 10'h3fc;
    localparam logic [9:0] OP_SETCARRY   = 10'h007;
    localparam logic [9:0] MSK_FULL      = 10'h3ff;
    localparam logic [9:0] OP_SETPORT    = 10'h015;
    localparam logic [9:0] OP_CMP_FIRST  = 10'h026;

    // Second word of the compare: fixed upper part, nibble below
    localparam logic [9:0] OP_CMP_SECOND = 10'h070;
    localparam logic [9:0] MSK_CMP_SEC   = 10'h3f0;

    // Index register range that may address a port bit
    localparam logic [3:0] PORT_IDX_MAX  = 4'h3;

    // Reset values
    localparam logic       CARRY_RST     = 1'b0;
    localparam logic       PORT_BIT_RST  = 1'b0;

    // Compare sequencer states
    typedef enum logic [0:0] {
        BSC_ST_FIRST  = 1'b0,
        BSC_ST_SECOND = 1'b1
    } bsc_state_t;

endpackage

// ---- bsc_exec.sv ----
// Operation
// - Set-memory-bit sets bit j (0..3) of the word at the data pointer.
// - Set-memory-bit code 0001011 1 jj; one word, one cycle, carry kept.
// - Set-port-bit sets port D bit at index register; one word, one cycle.
// - Compare-immediate skips next word if accumulator is n; carry kept.
// - Compare-immediate on inequality runs the next instruction normally.
// - Compare-immediate is two words, two cycles; second word 000111 nnnn.
`timescale 1ns/100ps
`default_nettype none

module bsc_exec #(
    // Address width of the data memory and width of port D
    parameter int unsigned DP_W   = 8,
    parameter int unsigned PORT_W = 4
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rstn_i,
    // Fetched word, one per machine cycle
    input  wire logic                     instr_valid_i,
    input  wire logic [bsc_pkg::IW_W-1:0] instr_i,
    // Core state read by the block
    input  wire logic [3:0]               acc_i,
    input  wire logic [3:0]               index_reg_i,
    input  wire logic [DP_W-1:0]          data_pointer_i,
    input  wire logic [3:0]               addressed_memory_word_i,
    // Carry written by the rest of the ALU
    input  wire logic                     carry_load_i,
    input  wire logic                     carry_value_i,
    // Data memory write port
    output logic                          mem_we_o,
    output logic [DP_W-1:0]               mem_addr_o,
    output logic [3:0]                    mem_wdata_o,
    // Flags, port and sequencing
    output logic                          carry_flag_o,
    output logic [PORT_W-1:0]             port_d_o,
    output logic                          skip_o,
    output logic                          exec_done_o,
    output logic                          second_word_o
);
    import bsc_pkg::*;

    // Each word is taken on the rising edge where it is valid; every
    // effect shows one cycle later from a register, so the core sees
    // the same latency for all four instructions handled here. Outside
    // second-word state, words that match none of the four opcodes pass without any effect.

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // The port must hold every index that may be addressed
    if (PORT_W < 4 || PORT_W > 16) begin : g_bad_port
        $error("PORT_W must be between 4 and 16");
    end
    if (DP_W < 1) begin : g_bad_dp
        $error("DP_W must be at least 1");
    end

    // Fields must sit inside the word, or the decode reads past its top
    if (BSEL_LSB + BSEL_W > IW_W) begin : g_bad_bsel
        $error("Bit-select field does not fit the word");
    end
    if (IMM_LSB + NIB_W > IW_W) begin : g_bad_imm
        $error("Immediate field does not fit the word");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode

    // Masked opcode match, shared by every decoder below
    // The mask lets the set-bit select field ride inside its pattern
    function automatic logic op_hit(input logic [9:0] word,
                                    input logic [9:0] pat,
                                    input logic [9:0] msk);
        op_hit = ((word & msk) == (pat & msk));
    endfunction

    // Compare pair tracking; the output mirror reads the next state
    bsc_state_t state_q;
    bsc_state_t state_d;

    // Decoded strobes, each true only in the cycle that takes its word
    logic       first_word;
    logic       is_setbit;
    logic       is_setcarry;
    logic       is_setport;
    logic       is_cmp1;
    logic       is_cmp2;
    logic       cmp_equal;
    logic [1:0] bit_sel;
    logic [3:0] imm_nib;

    // A second compare word is never decoded as an instruction of its own;
    // a word arriving in second-word state only ends or aborts the pair
    assign first_word  = instr_valid_i && (state_q == BSC_ST_FIRST);
    assign is_setbit   = first_word
                         && op_hit(instr_i, OP_SETBIT, MSK_SETBIT);
    assign is_setcarry = first_word
                         && op_hit(instr_i, OP_SETCARRY, MSK_FULL);
    assign is_setport  = first_word
                         && op_hit(instr_i, OP_SETPORT, MSK_FULL);
    assign is_cmp1     = first_word
                         && op_hit(instr_i, OP_CMP_FIRST, MSK_FULL);
    assign is_cmp2     = instr_valid_i && (state_q == BSC_ST_SECOND)
                         && op_hit(instr_i, OP_CMP_SECOND, MSK_CMP_SEC);
    assign bit_sel     = instr_i[BSEL_LSB +: BSEL_W];
    assign imm_nib     = instr_i[IMM_LSB +: NIB_W];
    assign cmp_equal   = (acc_i == imm_nib);

    ////////////////////////////////////////////////////////////////////////
    // Compare sequencer

    // Holds the compare across its second word; a stray word aborts it
    // An abort yields no skip and no done, so a lost second word cannot
    // leave a skip armed for some later instruction
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BSC_ST_FIRST: begin
                if (is_cmp1) begin
                    state_d = BSC_ST_SECOND;
                end
            end
            BSC_ST_SECOND: begin
                if (instr_valid_i) begin
                    state_d = BSC_ST_FIRST;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= BSC_ST_FIRST;
        end else begin
            state_q <= state_d;
        end
    end

    // Mirror flop, so the output comes straight from a register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            second_word_o <= 1'b0;
        end else begin
            second_word_o <= (state_d == BSC_ST_SECOND);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Skip and completion strobes

    // One-cycle skip request to the program counter after the second word
    // Limitation: the counter must apply the pulse to the very next word;
    // a skip that arrives after a further fetch is lost
    // Done also marks a finished compare, so the core can count cycles
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            skip_o      <= 1'b0;
            exec_done_o <= 1'b0;
        end else begin
            skip_o      <= is_cmp2 && cmp_equal;
            exec_done_o <= is_setbit || is_setcarry || is_setport || is_cmp2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data memory bit set

    // Read-modify-write in one cycle: the word is already on the read port
    // Hazard: a read port that lags the data pointer merges stale bits,
    // so the memory read must settle within the same cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_we_o    <= 1'b0;
            mem_addr_o  <= '0;
            mem_wdata_o <= 4'h0;
        end else begin
            mem_we_o <= is_setbit;
            if (is_setbit) begin
                mem_addr_o  <= data_pointer_i;
                mem_wdata_o <= addressed_memory_word_i
                               | (4'h1 << bit_sel);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Carry flag

    // Set-carry wins over an ALU load in the same cycle; they cannot
    // legally coincide, so the order only matters for bad stimulus
    // Set-bit, set-port and compare leave the flag alone
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            carry_flag_o <= CARRY_RST;
        end else if (is_setcarry) begin
            carry_flag_o <= 1'b1;
        end else if (carry_load_i) begin
            carry_flag_o <= carry_value_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port D output latches

    // Indices above the legal range are dropped rather than wrapped,
    // so an out-of-range index cannot disturb a bit already lit
    // Bits are only ever set here; clearing belongs to other instructions
    for (genvar gi = 0; gi < PORT_W; gi++) begin : g_port
        always_ff @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
                port_d_o[gi] <= PORT_BIT_RST;
            end else if (is_setport && (index_reg_i <= PORT_IDX_MAX)
                         && (index_reg_i == 4'(gi))) begin
                port_d_o[gi] <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- bsc_exec_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module bsc_exec_chk #(
    parameter int unsigned PORT_W = 4
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire logic              instr_valid_i,
    input  wire logic [9:0]        instr_i,
    input  wire logic [3:0]        acc_i,
    input  wire logic [3:0]        index_reg_i,
    input  wire logic [3:0]        addressed_memory_word_i,
    input  wire logic              carry_load_i,
    input  wire logic              mem_we_o,
    input  wire logic [3:0]        mem_wdata_o,
    input  wire logic              carry_flag_o,
    input  wire logic [PORT_W-1:0] port_d_o,
    input  wire logic              skip_o,
    input  wire logic              exec_done_o,
    input  wire logic              second_word_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // A word in second-word state is never a new opcode
    logic fw, sb;
    assign fw = instr_valid_i && !second_word_o;
    assign sb = fw && instr_i[9:2] == 8'h17;
    // Compare pair; a gap between the words is legal but not covered
    sequence s_cmp;
        fw && instr_i == 10'h026 ##1 instr_valid_i && instr_i[9:4] == 6'h07;
    endsequence
    sequence s_eq; s_cmp ##0 acc_i == instr_i[3:0]; endsequence
    sequence s_ne; s_cmp ##0 acc_i != instr_i[3:0]; endsequence
    a_set_bit: assert property (sb |=> mem_we_o && exec_done_o &&
        mem_wdata_o == ($past(addressed_memory_word_i) |
        4'(1 << $past(instr_i[1:0])))) else $error("bit write");
    a_bit_carry: assert property (sb && !carry_load_i |=>
        $stable(carry_flag_o)) else $error("carry moved");
    a_carry_set: assert property (fw && instr_i == 10'h007 |=>
        carry_flag_o && exec_done_o && !skip_o) else $error("carry");
    a_port_set: assert property (fw && instr_i == 10'h015 &&
        index_reg_i < 4 |=> port_d_o[$past(index_reg_i[1:0])])
        else $error("port bit");
    a_cmp_wait: assert property (fw && instr_i == 10'h026 |=>
        second_word_o && !exec_done_o) else $error("compare wait");
    a_skip_eq: assert property (s_eq |=> skip_o && exec_done_o)
        else $error("no skip");
    a_skip_ne: assert property (s_ne |=> !skip_o && exec_done_o)
        else $error("false skip");
    a_skip_src: assert property (skip_o |-> $past(second_word_o))
        else $error("stray skip");
    // A stray second word aborts the pair with no effect at all
    a_cmp_abort: assert property (second_word_o && instr_valid_i &&
        instr_i[9:4] != 6'h07 |=> !skip_o && !exec_done_o && !mem_we_o
        && !second_word_o) else $error("abort");
endmodule
bind bsc_exec bsc_exec_chk #(
    .PORT_W(PORT_W)
) i_bsc_exec_chk (
    .clk_sys_i              (clk_sys_i),
    .rstn_i                 (rstn_i),
    .instr_valid_i          (instr_valid_i),
    .instr_i                (instr_i),
    .acc_i                  (acc_i),
    .index_reg_i            (index_reg_i),
    .addressed_memory_word_i(addressed_memory_word_i),
    .carry_load_i           (carry_load_i),
    .mem_we_o               (mem_we_o),
    .mem_wdata_o            (mem_wdata_o),
    .carry_flag_o           (carry_flag_o),
    .port_d_o               (port_d_o),
    .skip_o                 (skip_o),
    .exec_done_o            (exec_done_o),
    .second_word_o          (second_word_o)
);
`default_nettype wire

// ---- bsc_fetch_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module bsc_fetch_model (
    input  wire logic       clk_sys_i,
    output var  logic       instr_valid_o,
    output var  logic [9:0] instr_o
);
    // Bus released at start
    initial begin
        instr_valid_o = 1'b0;
        instr_o = 10'h3ff;
    end
    // One word per call, launched just after an edge; calls may be
    // back to back, so both compare words can go out unbroken
    task automatic issue(input logic [9:0] w);
        @(posedge clk_sys_i);
        #1;
        instr_valid_o = 1'b1;
        instr_o = w;
    endtask
    // Released bus shows the inverse, so a stale word cannot pass
    task automatic idle;
        @(posedge clk_sys_i);
        #1;
        instr_valid_o = 1'b0;
        instr_o = ~instr_o;
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    fail_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic       clk_sys_i = 1'b0, rstn_i = 1'b0;
    logic       carry_load_i = 1'b0, carry_value_i = 1'b0;
    logic [3:0] acc_i = 4'h9, index_reg_i = 4'h0;
    logic [3:0] addressed_memory_word_i = 4'h0, mem_wdata_o, port_d_o;
    logic [7:0] data_pointer_i = 8'h00, mem_addr_o;
    logic       instr_valid_i, mem_we_o, carry_flag_o, skip_o;
    logic       exec_done_o, second_word_o;
    logic [9:0] instr_i;
    int         fail_count = 0, comparisons = 0, cycles = 0;
    bsc_fetch_model i_bsc_fetch_model (.clk_sys_i,
        .instr_valid_o(instr_valid_i), .instr_o(instr_i));
    bsc_exec i_bsc_exec (
        .clk_sys_i              (clk_sys_i),
        .rstn_i                 (rstn_i),
        .instr_valid_i          (instr_valid_i),
        .instr_i                (instr_i),
        .acc_i                  (acc_i),
        .index_reg_i            (index_reg_i),
        .data_pointer_i         (data_pointer_i),
        .addressed_memory_word_i(addressed_memory_word_i),
        .carry_load_i           (carry_load_i),
        .carry_value_i          (carry_value_i),
        .mem_we_o               (mem_we_o),
        .mem_addr_o             (mem_addr_o),
        .mem_wdata_o            (mem_wdata_o),
        .carry_flag_o           (carry_flag_o),
        .port_d_o               (port_d_o),
        .skip_o                 (skip_o),
        .exec_done_o            (exec_done_o),
        .second_word_o          (second_word_o)
    );
    // Clock, and a cycle ceiling well above the fewer than a hundred needed
    initial forever #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles > 1000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic go(input logic [9:0] w);
        i_bsc_fetch_model.issue(w);
    endtask
    task automatic nop;
        i_bsc_fetch_model.idle();
    endtask
    ////////////////////////////////////////////////////////////////
    // Memory word has all bits but j set, so a wrong position shows
    task automatic t_setbit;
        for (int j = 0; j < 4; j++) begin
            data_pointer_i = 8'h40 + 8'(j);
            addressed_memory_word_i = 4'hf ^ 4'(1 << j);
            go(10'h05c | 10'(j));
            nop();
            `CHK({mem_we_o, exec_done_o, carry_flag_o}, 3'b110)
            `CHK({mem_addr_o, mem_wdata_o}, {8'h40 + 8'(j), 4'hf})
        end
        nop();
        `CHK(mem_we_o, 1'b0)
        $display("set bit test over");
    endtask
    // Load of zero in the same cycle must lose to set-carry
    task automatic t_carry;
        carry_load_i = 1'b1;
        go(10'h007);
        nop();
        carry_load_i = 1'b0;
        `CHK({carry_flag_o, exec_done_o, skip_o}, 3'b110)
        $display("carry test over");
    endtask
    // Indices 4 and 5 probe the undefined case first, while every bit
    // is still clear, so a wrapped index would light a bit and show
    task automatic t_port;
        logic [3:0] exp = 4'h0;
        logic [3:0] idx;
        for (int y = 0; y < 6; y++) begin
            idx = 4'((y + 4) % 6);
            index_reg_i = idx;
            go(10'h015);
            nop();
            if (idx < 4)
                exp[idx[1:0]] = 1'b1;
            `CHK({port_d_o, exec_done_o}, {exp, 1'b1})
        end
        $display("port test over");
    endtask
    // All sixteen immediates against a fixed accumulator, then an abort
    task automatic t_cmp;
        for (int n = 0; n < 16; n++) begin
            go(10'h026);
            go(10'h070 | 10'(n));
            `CHK({second_word_o, exec_done_o}, 2'b10)
            nop();
            `CHK({skip_o, exec_done_o, carry_flag_o}, {n == 9, 2'b11})
        end
        go(10'h026);
        go(10'h05c);
        nop();
        `CHK({skip_o, exec_done_o, mem_we_o, second_word_o}, 4'h0)
        $display("compare test over");
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1 rstn_i = 1'b1;
        `CHK({carry_flag_o, port_d_o, skip_o, mem_we_o}, 7'h00)
        t_setbit();
        t_carry();
        t_port();
        t_cmp();
        report_and_stop();
    end
endmodule
`default_nettype wire
